// >>> bench/cmfc_can_far.sv
`timescale 1ns/1ns
module cmfc_can_far #(
   parameter int NB = 8
) (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          sys_rst_i,
   // Bench commands
   input  wire logic          load_i,
   input  wire logic          frame_i,
   input  wire logic          stall_i,
   // Controller side
   input  wire logic [NB-1:0] tx_abort_i,
   output logic [NB-1:0]      tx_pending_o,
   output logic               engine_active_o,
   output logic               rx_valid_msg_o,
   output logic               stamp_ready_o
);
   logic [4:0] busy_r;
   logic [2:0] abt_r;
   logic       ph_r;
   assign engine_active_o = busy_r != 5'h0;
   assign rx_valid_msg_o  = busy_r == 5'h1;
   // Sink takes every other cycle so stamps queue up
   assign stamp_ready_o   = !stall_i && ph_r;
   always_ff @(posedge clk_i) begin
      ph_r <= !sys_rst_i && !ph_r;
      if (sys_rst_i) begin
         busy_r <= 5'h0;
         abt_r <= 3'h0;
         tx_pending_o <= '0;
      end else begin
         if (frame_i)
            busy_r <= 5'h14;
         else if (busy_r != 5'h0)
            busy_r <= busy_r - 5'h1;
         if (load_i)
            tx_pending_o <= '1;
         // Buffers need a few cycles to wind down after abort
         if (|(tx_abort_i & tx_pending_o))
            abt_r <= abt_r + 3'h1;
         if (abt_r == 3'h7) begin
            tx_pending_o <= '0;
            abt_r <= 3'h0;
         end
      end
   end
endmodule

// >>> bench/cmfc_top_props.sv
`timescale 1ns/1ns
module cmfc_top_props
   import cmfc_pkg::*;
#(
   parameter int NUM_TXBUF  = 8,
   parameter int TS_WIDTH   = 16,
   parameter int FIFO_DEPTH = 4
) (
   // Clock, reset and bus
   input wire logic                 clk_i,
   input wire logic                 sys_rst_i,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [3:0]           wb_adr_i,
   input wire logic [3:0]           wb_sel_i,
   input wire logic [31:0]          wb_dat_i,
   input wire logic                 wb_ack_o,
   // Engine, filters and stamps
   input wire logic [NUM_TXBUF-1:0] tx_abort_o,
   input wire logic [NUM_TXBUF-1:0] tx_pending_i,
   input wire logic                 engine_active_i,
   input wire logic [2:0]           mode_status_o,
   input wire logic [1:0]           filter_enable_o,
   input wire logic [3:0]           filter_mask_choice_o,
   input wire logic [9:0]           filter_fifo_dest_o,
   input wire logic                 rx_stamp_valid_o,
   input wire logic                 rx_stamp_ready_i,
   input wire logic [TS_WIDTH-1:0]  rx_stamp_o
);
   logic [3:0] since_wr;
   logic       flt_wr;
   assign flt_wr = wb_ack_o && wb_we_i && wb_adr_i == CMFC_ADDR_FLT5;
   // Cycles since the last control write, saturating
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || (wb_ack_o && wb_we_i && wb_adr_i == CMFC_ADDR_CTRL))
         since_wr <= 4'h0;
      else if (since_wr != 4'hf)
         since_wr <= since_wr + 4'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   chk_abort_whole: assert property (tx_abort_o == '0 || tx_abort_o == '1)
      else $error("abort not sent to all buffers");
   chk_abort_release: assert property ($fell(tx_abort_o[0]) |-> $past(tx_pending_i, 2) == '0)
      else $error("abort cleared while buffers pending");
   chk_mode_idle: assert property ($changed(mode_status_o) |->
      $past(!engine_active_i && tx_pending_i == '0, 2))
      else $error("mode changed during activity");
   chk_mode_drain: assert property ($changed(mode_status_o) |-> since_wr >= 4'h6)
      else $error("mode changed before drain");
   chk_flt_layout: assert property (flt_wr && wb_sel_i[1] && !$past(filter_enable_o[1]) |->
      {filter_enable_o[1], filter_mask_choice_o[3:2], filter_fifo_dest_o[9:5]} == wb_dat_i[15:8])
      else $error("filter byte layout wrong");
   chk_flt_enable: assert property (flt_wr && wb_sel_i[0] |-> filter_enable_o[0] == wb_dat_i[7])
      else $error("filter enable not written");
   chk_flt_locked: assert property (flt_wr && wb_sel_i[0] && $past(filter_enable_o[0]) |->
      $stable(filter_mask_choice_o[1:0]) && $stable(filter_fifo_dest_o[4:0]))
      else $error("locked filter fields changed");
   chk_stamp_hold: assert property (rx_stamp_valid_o && !rx_stamp_ready_i |=>
      rx_stamp_valid_o && $stable(rx_stamp_o))
      else $error("stamp dropped while stalled");
   cov_abort: cover property ($fell(tx_abort_o[0]));
   cov_mode: cover property ($changed(mode_status_o));
   cov_stall: cover property (rx_stamp_valid_o && !rx_stamp_ready_i);
endmodule
bind cmfc_top cmfc_top_props #(.NUM_TXBUF(NUM_TXBUF), .TS_WIDTH(TS_WIDTH),
   .FIFO_DEPTH(FIFO_DEPTH)) i_cmfc_top_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .tx_abort_o(tx_abort_o),
   .tx_pending_i(tx_pending_i), .engine_active_i(engine_active_i),
   .mode_status_o(mode_status_o), .filter_enable_o(filter_enable_o),
   .filter_mask_choice_o(filter_mask_choice_o), .filter_fifo_dest_o(filter_fifo_dest_o),
   .rx_stamp_valid_o(rx_stamp_valid_o), .rx_stamp_ready_i(rx_stamp_ready_i),
   .rx_stamp_o(rx_stamp_o));

// >>> bench/tb_cmfc_top.sv
`timescale 1ns/1ns
module tb_cmfc_top;
   import cmfc_pkg::*;
   logic        clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]  wb_adr_i, wb_sel_i, filter_mask_choice_o;
   logic [31:0] wb_dat_i, wb_dat_o, rd, t1;
   logic [7:0]  tx_abort_o, tx_pending_i;
   logic        engine_active_i, rx_valid_msg_i, module_enable_o, rx_stamp_drop_o;
   logic        rx_stamp_valid_o, rx_stamp_ready_i, load, frame, stall;
   logic [2:0]  mode_status_o, prev;
   logic [1:0]  filter_enable_o;
   logic [9:0]  filter_fifo_dest_o;
   logic [15:0] rx_stamp_o, last_st, old, nw;
   int          num_errors = 0, cmp_count = 0, cycles = 0, n_st = 0, n0, seed;
   logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
   cmfc_top i_cmfc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .tx_abort_o(tx_abort_o), .tx_pending_i(tx_pending_i),
      .engine_active_i(engine_active_i), .rx_valid_msg_i(rx_valid_msg_i),
      .module_enable_o(module_enable_o), .mode_status_o(mode_status_o),
      .filter_enable_o(filter_enable_o), .filter_mask_choice_o(filter_mask_choice_o),
      .filter_fifo_dest_o(filter_fifo_dest_o), .rx_stamp_valid_o(rx_stamp_valid_o),
      .rx_stamp_ready_i(rx_stamp_ready_i), .rx_stamp_o(rx_stamp_o),
      .rx_stamp_drop_o(rx_stamp_drop_o));
   cmfc_can_far i_cmfc_can_far (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_i(load),
      .frame_i(frame), .stall_i(stall), .tx_abort_i(tx_abort_o),
      .tx_pending_o(tx_pending_i), .engine_active_o(engine_active_i),
      .rx_valid_msg_o(rx_valid_msg_i), .stamp_ready_o(rx_stamp_ready_i));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // Read control until the masked field matches, bounded
   task automatic poll(input logic [31:0] mask, input logic [31:0] val);
      int n;
      n = 0;
      do begin
         wb(1'b0, CMFC_ADDR_CTRL, 32'h0);
         n++;
      end while ((rd & mask) !== val && n < 100);
   endtask
   task automatic send();
      frame <= 1'b1;
      @(posedge clk_i);
      frame <= 1'b0;
      repeat (24) @(posedge clk_i);
   endtask
   function automatic logic [31:0] ctl(input logic ab, input logic [2:0] m,
                                       input logic cap, input logic on);
      return {4'h0, ab, m, 3'h0, cap, 4'h0, on, 15'h0};
   endfunction
   // Expected control readback, busy follows enable once settled
   function automatic logic [31:0] ctl_rd(input logic [2:0] m, input logic cap, input logic on);
      return {5'h0, m, m, cap, 4'h0, on, 3'h0, on, 11'h0};
   endfunction
   // Fields of an enabled filter keep their old value
   function automatic logic [15:0] flt(input logic [15:0] o, input logic [15:0] n);
      for (int b = 0; b < 2; b++)
         if (o[8*b+7])
            n[8*b +: 7] = o[8*b +: 7];
      return n;
   endfunction
   always @(posedge clk_i) begin
      cycles++;
      if (rx_stamp_valid_o === 1'b1 && rx_stamp_ready_i) begin
         if (n_st > 0)
            check(32'(rx_stamp_o > last_st), 32'h1);
         last_st = rx_stamp_o;
         n_st++;
      end
      if (cycles == 20000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, load, frame, stall} = 6'h0;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      sys_rst_i = 1'b1;
      seed = 38006;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      wb(1'b0, CMFC_ADDR_CTRL, 32'h0);
      check(rd, 32'h0480_0000);
      wb(1'b0, CMFC_ADDR_FLT5, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, 4'h2, 32'h0);
      check(rd, 32'h0);
      $display("reset test done");
      prev = 3'h4;
      foreach (modes[i]) begin
         wb(1'b1, CMFC_ADDR_CTRL, ctl(1'b0, modes[i], 1'b0, 1'b1));
         wb(1'b0, CMFC_ADDR_CTRL, 32'h0);
         check(32'(rd[23:21]), 32'(prev));
         poll(32'h00e0_0000, {8'h0, modes[i], 21'h0});
         check(rd, ctl_rd(modes[i], 1'b0, 1'b1));
         check(32'(mode_status_o), 32'(modes[i]));
         prev = modes[i];
      end
      $display("mode test done");
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
      wb(1'b1, CMFC_ADDR_CTRL, ctl(1'b1, 3'h4, 1'b0, 1'b1));
      wb(1'b0, CMFC_ADDR_CTRL, 32'h0);
      check(32'(rd[27]), 32'h1);
      check(32'(tx_abort_o), 32'hff);
      poll(32'h0800_0000, 32'h0);
      check(32'(tx_pending_i | tx_abort_o), 32'h0);
      $display("abort test done");
      send();
      frame <= 1'b1;
      @(posedge clk_i);
      frame <= 1'b0;
      wb(1'b1, CMFC_ADDR_CTRL, ctl(1'b0, 3'h4, 1'b0, 1'b0));
      check(32'(module_enable_o), 32'h0);
      wb(1'b0, CMFC_ADDR_CTRL, 32'h0);
      check(32'(rd[11]), 32'h1);
      poll(32'h0000_0800, 32'h0);
      check(32'(engine_active_i), 32'h0);
      check(rd, ctl_rd(3'h4, 1'b0, 1'b0));
      $display("disable test done");
      old = 16'h0;
      for (int i = 0; i < 12; i++) begin
         nw = (i == 0) ? 16'h8080 : (i == 1) ? 16'h7f7f : 16'($random(seed));
         wb(1'b1, CMFC_ADDR_FLT5, {16'($random(seed)), nw});
         old = flt(old, nw);
         wb(1'b0, CMFC_ADDR_FLT5, 32'h0);
         check(rd, {16'h0, old});
         check(32'({filter_enable_o, filter_mask_choice_o, filter_fifo_dest_o}),
               32'({old[15], old[7], old[14:13], old[6:5], old[12:8], old[4:0]}));
      end
      $display("filter test done");
      wb(1'b1, CMFC_ADDR_CTRL, ctl(1'b0, 3'h4, 1'b1, 1'b1));
      wb(1'b0, CMFC_ADDR_TSTMR, 32'h0);
      t1 = rd;
      wb(1'b0, CMFC_ADDR_TSTMR, 32'h0);
      check(32'(rd > t1), 32'h1);
      stall <= 1'b1;
      wb(1'b0, CMFC_ADDR_RXTS, 32'h0);
      // Buffer plus output register hold five stamps; the sixth is lost
      repeat (6) send();
      check(32'(rx_stamp_drop_o), 32'h1);
      wb(1'b0, CMFC_ADDR_RXTS, 32'h0);
      check(32'(rd[31]), 32'h1);
      check(32'(rx_stamp_drop_o), 32'h0);
      n0 = n_st;
      stall <= 1'b0;
      repeat (40) @(posedge clk_i);
      check(32'(n_st - n0), 32'h5);
      wb(1'b1, CMFC_ADDR_CTRL, ctl(1'b0, 3'h4, 1'b0, 1'b1));
      wb(1'b0, CMFC_ADDR_TSTMR, 32'h0);
      t1 = rd;
      send();
      wb(1'b0, CMFC_ADDR_TSTMR, 32'h0);
      check(rd, t1);
      check(32'(n_st - n0), 32'h5);
      $display("stamp test done");
      conclude();
   end
endmodule

// >>> verilog/cmfc_fifo.sv
`timescale 1ns/1ns
module cmfc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("cmfc_fifo depth must be a power of two, at least 2");
      end
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } cmfc_fifo_s;

   cmfc_fifo_s q_r;
   cmfc_fifo_s q_nxt;
   logic       push;
   logic       pop;

   // Full compare at counter width; a narrower cast of DEPTH wraps to zero
   assign in_ready_o  = (q_r.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (q_r.cnt != '0);
   assign out_data_o  = q_r.mem[q_r.rp];

   always_comb begin
      q_nxt = q_r;
      push  = in_valid_i && in_ready_o;
      pop   = out_valid_o && out_ready_i;
      if (push) begin
         q_nxt.mem[q_r.wp] = in_data_i;
         q_nxt.wp          = q_r.wp + AW'(1);
      end
      if (pop) begin
         q_nxt.rp = q_r.rp + AW'(1);
      end
      if (push && !pop) begin
         q_nxt.cnt = q_r.cnt + (AW+1)'(1);
      end else if (pop && !push) begin
         q_nxt.cnt = q_r.cnt - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

endmodule

// >>> verilog/cmfc_pkg.sv
package cmfc_pkg;

   // ---------------------------------------------------------------
   // Register map (word byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] CMFC_ADDR_CTRL  = 4'h0;
   localparam logic [3:0] CMFC_ADDR_FLT5  = 4'h4;
   localparam logic [3:0] CMFC_ADDR_TSTMR = 4'h8;
   localparam logic [3:0] CMFC_ADDR_RXTS  = 4'hc;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int CMFC_ABORT_BIT  = 27;
   localparam int CMFC_REQ_LSB    = 24;
   localparam int CMFC_STAT_LSB   = 21;
   localparam int CMFC_CAP_BIT    = 20;
   localparam int CMFC_ON_BIT     = 15;
   localparam int CMFC_STOP_IN_IDLE_BIT  = 13;
   localparam int CMFC_BUSY_BIT   = 11;
   localparam int CMFC_DATA_BYTE_NET_COUNT_LSB  = 0;

   // Filter byte layout: enable top, mask choice two, fifo dest low five
   localparam int CMFC_FLT_EN_BIT = 7;
   localparam int CMFC_FLT_MS_LSB = 5;
   localparam int CMFC_FLT_FD_LSB = 0;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] CMFC_REQ_RST  = 3'h4;
   localparam logic [2:0] CMFC_STAT_RST = 3'h4;

   // Cycles taken to wind down activity before a mode change lands
   localparam logic [3:0] CMFC_DRAIN_CYC = 4'h8;

   // ---------------------------------------------------------------
   // Operating modes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CMFC_MODE_NORMAL   = 3'h0,
      CMFC_MODE_DISABLE  = 3'h1,
      CMFC_MODE_LOOPBACK = 3'h2,
      CMFC_MODE_LISTEN   = 3'h3,
      CMFC_MODE_CONFIG   = 3'h4,
      CMFC_MODE_RSV5     = 3'h5,
      CMFC_MODE_RSV6     = 3'h6,
      CMFC_MODE_LISTALL  = 3'h7
   } cmfc_mode_e;

   typedef enum logic [1:0] {
      CMFC_ST_IDLE  = 2'b00,
      CMFC_ST_DRAIN = 2'b01,
      CMFC_ST_APPLY = 2'b11
   } cmfc_state_e;

endpackage

// >>> verilog/cmfc_top.sv
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module cmfc_top
   import cmfc_pkg::*;
#(
   parameter int NUM_TXBUF = 8,
   parameter int TS_WIDTH  = 16,
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   // Wishbone classic slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [3:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   // Transmit buffers
   output logic [NUM_TXBUF-1:0]      tx_abort_o,
   input  wire logic [NUM_TXBUF-1:0] tx_pending_i,
   // Protocol engine
   input  wire logic                 engine_active_i,
   input  wire logic                 rx_valid_msg_i,
   output logic                      module_enable_o,
   output logic [2:0]                mode_status_o,
   // Filters (twenty, twentyone)
   output logic [1:0]                filter_enable_o,
   output logic [3:0]                filter_mask_choice_o,
   output logic [9:0]                filter_fifo_dest_o,
   // Stamp stream to message store
   output logic                      rx_stamp_valid_o,
   input  wire logic                 rx_stamp_ready_i,
   output logic [TS_WIDTH-1:0]       rx_stamp_o,
   output logic                      rx_stamp_drop_o
);

   initial begin
      if (NUM_TXBUF < 1 || TS_WIDTH < 1 || TS_WIDTH > 32) begin
         $error("cmfc_top parameter out of range");
      end
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                abort;
      logic [2:0]          req;
      logic [2:0]          stat;
      logic                cap;
      logic                on;
      logic                stop_in_idle;
      logic [4:0]          data_byte_net_count;
      logic [15:0]         flt;
      logic                act;
      cmfc_state_e         st;
      logic [3:0]          drain;
      logic [TS_WIDTH-1:0] tmr;
      logic [TS_WIDTH-1:0] last_ts;
      logic                drop;
      logic                ack;
      logic [31:0]         dat;
      logic [NUM_TXBUF-1:0] txab;
   } cmfc_s;

   cmfc_s q_r;
   cmfc_s q_nxt;

   logic                wr;
   logic                rd;
   logic [31:0]         ctrl_rd;
   logic [31:0]         wmask;
   logic [31:0]         wval;
   logic [7:0]          fb;
   logic                busy;
   logic                push_v;
   logic                push_rdy;
   logic                idle_ok;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // One-cycle answer: ack the cycle after the request is seen
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !q_r.ack;
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !q_r.ack;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[8*i +: 8] = {8{wb_sel_i[i]}};
      end
   end

   assign busy    = q_r.act;
   assign idle_ok = !engine_active_i && (tx_pending_i == '0);

   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[CMFC_ABORT_BIT]              = q_r.abort;
      ctrl_rd[CMFC_REQ_LSB +: 3]           = q_r.req;
      ctrl_rd[CMFC_STAT_LSB +: 3]          = q_r.stat;
      ctrl_rd[CMFC_CAP_BIT]                = q_r.cap;
      ctrl_rd[CMFC_ON_BIT]                 = q_r.on;
      ctrl_rd[CMFC_STOP_IN_IDLE_BIT]              = q_r.stop_in_idle;
      ctrl_rd[CMFC_BUSY_BIT]               = busy;
      ctrl_rd[CMFC_DATA_BYTE_NET_COUNT_LSB +: 5]         = q_r.data_byte_net_count;
   end

   assign wval = wb_dat_i & wmask;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      q_nxt = q_r;
      fb    = '0;
      q_nxt.ack = wr || rd;

      if (rd) begin
         unique case (wb_adr_i)
            CMFC_ADDR_CTRL:  q_nxt.dat = ctrl_rd;
            CMFC_ADDR_FLT5:  q_nxt.dat = {16'h0000, q_r.flt};
            CMFC_ADDR_TSTMR: q_nxt.dat = 32'(q_r.tmr);
            CMFC_ADDR_RXTS:  q_nxt.dat = {q_r.drop, 31'(q_r.last_ts)};
            default:         q_nxt.dat = '0;
         endcase
      end

      // clear when all aborted
      // Evaluated before the bus write so that a new software set wins
      q_nxt.txab = q_r.abort ? {NUM_TXBUF{1'b1}} : '0;
      if (q_r.abort && q_r.txab != '0 && tx_pending_i == '0) begin
         q_nxt.abort = 1'b0;
      end

      if (wr && wb_adr_i == CMFC_ADDR_CTRL) begin
         if (wmask[CMFC_ABORT_BIT] && wb_dat_i[CMFC_ABORT_BIT]) begin
            q_nxt.abort = 1'b1;
         end
         if (wb_sel_i[3]) begin
            q_nxt.req = wb_dat_i[CMFC_REQ_LSB +: 3];
         end
         if (wb_sel_i[2]) begin
            q_nxt.cap = wb_dat_i[CMFC_CAP_BIT];
         end
         if (wb_sel_i[1]) begin
            q_nxt.on    = wb_dat_i[CMFC_ON_BIT];
            q_nxt.stop_in_idle = wb_dat_i[CMFC_STOP_IN_IDLE_BIT];
         end
         if (wb_sel_i[0]) begin
            q_nxt.data_byte_net_count = wb_dat_i[CMFC_DATA_BYTE_NET_COUNT_LSB +: 5];
         end
      end

      if (wr && wb_adr_i == CMFC_ADDR_FLT5) begin
         for (int f = 0; f < 2; f++) begin
            if (wb_sel_i[f]) begin
               fb = wval[8*f +: 8];
               q_nxt.flt[8*f + CMFC_FLT_EN_BIT] = fb[CMFC_FLT_EN_BIT];
               if (!q_r.flt[8*f + CMFC_FLT_EN_BIT]) begin
                  q_nxt.flt[8*f +: 7] = fb[6:0];
               end
            end
         end
      end

      // busy until the engine winds down
      if (q_r.on) begin
         q_nxt.act = 1'b1;
      end else if (idle_ok) begin
         q_nxt.act = 1'b0;
      end

      unique case (q_r.st)
         CMFC_ST_IDLE: begin
            if (q_r.req != q_r.stat) begin
               q_nxt.st    = CMFC_ST_DRAIN;
               q_nxt.drain = CMFC_DRAIN_CYC;
            end
         end
         CMFC_ST_DRAIN: begin
            if (q_r.drain != '0) begin
               q_nxt.drain = q_r.drain - 4'h1;
            end else if (idle_ok) begin
               q_nxt.st = CMFC_ST_APPLY;
            end
         end
         CMFC_ST_APPLY: begin
            q_nxt.stat = q_r.req;
            q_nxt.st   = CMFC_ST_IDLE;
         end
         default: q_nxt.st = CMFC_ST_IDLE;
      endcase

      // timer halts when capture is off
      if (q_r.cap && q_r.on) begin
         q_nxt.tmr = q_r.tmr + TS_WIDTH'(1);
      end
      if (q_r.cap && q_r.on && rx_valid_msg_i) begin
         q_nxt.last_ts = q_r.tmr;
         if (!push_rdy) begin
            q_nxt.drop = 1'b1;
         end
      end
      if (rd && wb_adr_i == CMFC_ADDR_RXTS && !(push_v && !push_rdy)) begin
         q_nxt.drop = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q_r       <= '0;
         q_r.req   <= CMFC_REQ_RST;
         q_r.stat  <= CMFC_STAT_RST;
         q_r.st    <= CMFC_ST_IDLE;
      end else begin
         q_r <= q_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Stamp buffer toward the message store
   // ----------------------------------------------------------------
   // stamp travels with message
   assign push_v = q_r.cap && q_r.on && rx_valid_msg_i;

   logic                fifo_v;
   logic [TS_WIDTH-1:0] fifo_d;
   logic                out_v_r;
   logic [TS_WIDTH-1:0] out_d_r;
   logic                take;

   cmfc_fifo #(
      .WIDTH (TS_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (push_v),
      .in_ready_o  (push_rdy),
      .in_data_i   (q_r.tmr),
      .out_valid_o (fifo_v),
      .out_ready_i (take),
      .out_data_o  (fifo_d)
   );

   // Output skid register keeps the port flop-driven
   assign take = fifo_v && (!out_v_r || rx_stamp_ready_i);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         out_v_r <= 1'b0;
         out_d_r <= '0;
      end else if (take) begin
         out_v_r <= 1'b1;
         out_d_r <= fifo_d;
      end else if (rx_stamp_ready_i) begin
         out_v_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_dat_o             = q_r.dat;
   assign wb_ack_o             = q_r.ack;
   assign tx_abort_o           = q_r.txab;
   assign module_enable_o      = q_r.on;
   assign mode_status_o        = q_r.stat;
   assign filter_enable_o      = {q_r.flt[15], q_r.flt[7]};
   assign filter_mask_choice_o = {q_r.flt[14:13], q_r.flt[6:5]};
   assign filter_fifo_dest_o   = {q_r.flt[12:8], q_r.flt[4:0]};
   assign rx_stamp_valid_o     = out_v_r;
   assign rx_stamp_o           = out_d_r;
   assign rx_stamp_drop_o      = q_r.drop;

endmodule
